// [design/prio_irq_defs.svh]
// Constants for the priority interrupt controller command-word block
`ifndef PRIO_IRQ_DEFS_SVH
`define PRIO_IRQ_DEFS_SVH
`define W4_RESET 8'h00
`define MASK_RESET 8'h00
`define BIT_INIT_ONE 4
`define BIT_READSEL 3
`define BIT_NEED_FOUR 0
`define BIT_SINGLE 1
`define BIT_SPECIAL_NESTED 4
`define BIT_BUFFERED 3
`define BIT_MASTER 2
`define BIT_AUTO_EOI 1
`define BIT_PROC_MODE 0
`define BIT_READ_REG 1
`define BIT_READ_ISR 0
`define CODE_NS_EOI 3'h1
`define CODE_SP_EOI 3'h3
`define CODE_ROT_NS_EOI 3'h5
`define CODE_ROT_AUTO_SET 3'h4
`define CODE_ROT_AUTO_CLR 3'h0
`define CODE_ROT_SP_EOI 3'h7
`define CODE_SET_PRIO 3'h6
`define CODE_NOP 3'h2
`endif

// [design/prio_irq_pkg.sv]
// Types shared by the priority interrupt controller command-word block
package prio_irq_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_TWO,
		ST_WAIT_THREE,
		ST_WAIT_FOUR,
		ST_READY
	} init_state_t;

	typedef struct packed {
		logic special_nested_sel;
		logic buffered;
		logic master;
		logic auto_eoi_sel;
		logic processor_mode_sel;
	} mode_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic register_select_line;
		logic [7:0] data;
	} host_access_t;
endpackage : prio_irq_pkg

// [design/prio_irq_command_words.sv]
// Command-word logic of an eight-input programmable priority controller
`timescale 1ns/1ps
`include "prio_irq_defs.svh"
module prio_irq_command_words #(
	parameter int LINES = 8
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire prio_irq_pkg::host_access_t host_i,
	input wire logic [LINES-1:0] request_line_i,
	input wire logic ack_i,
	input wire logic role_or_buffer_enable_pin_i,
	output logic role_or_buffer_enable_pin_o,
	output logic role_or_buffer_enable_pin_oe_o,
	output logic [7:0] read_data_o,
	output logic irq_o,
	output logic [2:0] ack_level_o,
	output logic is_master_o,
	output logic special_nested_o,
	output logic processor_mode_o,
	output logic ready_o
);
	import prio_irq_pkg::*;

	// Reset release and pin synchronisers
	logic rst_meta, rst_sync;
	logic [LINES-1:0] req_meta, req_sync;
	logic pin_meta, pin_sync;
	logic ack_meta, ack_sync, ack_prev;
	logic rd_meta, rd_sync, rd_prev;
	logic wr_meta, wr_sync, wr_prev;
	logic [8:0] bus_meta, bus_sync;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Every pin crosses two flops; the second stage is read, and strobes also feed a third flop for edge detect
	always_ff @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			{req_meta, req_sync} <= '0;
			{pin_meta, pin_sync} <= 2'h3;
			{ack_meta, ack_sync, ack_prev} <= 3'h0;
			{rd_meta, rd_sync, rd_prev} <= 3'h0;
			{wr_meta, wr_sync, wr_prev} <= 3'h0;
			{bus_meta, bus_sync} <= '0;
		end
		else if (enable_i)
		begin
			{req_sync, req_meta} <= {req_meta, request_line_i};
			{pin_sync, pin_meta} <= {pin_meta, role_or_buffer_enable_pin_i};
			{ack_prev, ack_sync, ack_meta} <= {ack_sync, ack_meta, ack_i};
			{rd_prev, rd_sync, rd_meta} <= {rd_sync, rd_meta, host_i.rd};
			{wr_prev, wr_sync, wr_meta} <= {wr_sync, wr_meta, host_i.wr};
			bus_meta <= {host_i.register_select_line, host_i.data};
			bus_sync <= bus_meta;
		end
	end

	// Write decode on the write strobe's falling edge (data stable)
	wire wr_done = wr_prev && !wr_sync;
	wire rd_start = rd_sync && !rd_prev;
	wire sel = bus_sync[8];
	wire [7:0] d = bus_sync[7:0];
	wire [2:0] code = d[7:5];
	wire [2:0] level = d[2:0];
	wire is_word_one = wr_done && !sel && d[`BIT_INIT_ONE];
	wire is_readsel = wr_done && !sel && !d[`BIT_INIT_ONE]
		&& d[`BIT_READSEL];
	wire is_eoi_word = wr_done && !sel && !d[`BIT_INIT_ONE]
		&& !d[`BIT_READSEL];
	wire is_mask_word = wr_done && sel;
	wire ack_end = ack_prev && !ack_sync;

	init_state_t state, next_state;
	logic need_four, single;
	mode_cfg_t cfg;
	logic [7:0] mask, pending, in_service, req_prev;
	logic [2:0] lowest, taken_level;
	logic rotate_auto, read_isr, ack_taken;
	wire ready = (state == ST_READY);

	// Initialization sequence; word one restarts it from any state
	always_comb
	begin
		next_state = state;
		if (is_word_one)
			next_state = ST_WAIT_TWO;
		else if (wr_done && sel)
		begin
			case (state)
				ST_WAIT_TWO:
					next_state = !single ? ST_WAIT_THREE
						: (need_four ? ST_WAIT_FOUR : ST_READY);
				ST_WAIT_THREE:
					next_state = need_four ? ST_WAIT_FOUR : ST_READY;
				ST_WAIT_FOUR:
					next_state = ST_READY;
				// Ready and idle hold; select-high writes in idle are dropped
				default:
					next_state = state;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			state <= ST_IDLE;
			need_four <= 1'b0;
			single <= 1'b1;
		end
		else if (enable_i)
		begin
			state <= next_state;
			if (is_word_one)
			begin
				need_four <= d[`BIT_NEED_FOUR];
				single <= d[`BIT_SINGLE];
			end
		end
	end

	// Mode word: defaults to zero when not requested
	always_ff @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
			cfg <= '0;
		else if (enable_i)
		begin
			if (is_word_one)
				cfg <= '0;
			else if (wr_done && sel && state == ST_WAIT_FOUR)
			begin
				cfg.special_nested_sel <= d[`BIT_SPECIAL_NESTED];
				cfg.buffered <= d[`BIT_BUFFERED];
				cfg.master <= d[`BIT_MASTER];
				cfg.auto_eoi_sel <= d[`BIT_AUTO_EOI];
				cfg.processor_mode_sel <= d[`BIT_PROC_MODE];
			end
		end
	end

	// Highest-priority unmasked request relative to rotation point
	logic [2:0] top_level;
	logic top_valid;
	always_comb
	begin
		logic [2:0] idx;
		idx = 3'h0;
		top_level = 3'h0;
		top_valid = 1'b0;
		for (int k = 7; k >= 0; k--)
		begin
			idx = lowest + 3'(k + 1);
			if (pending[idx] && !mask[idx])
			begin
				top_level = idx;
				top_valid = 1'b1;
			end
		end
	end

	// Highest-priority in-service bit, for non-specific end-of-interrupt
	logic [2:0] isr_level;
	logic isr_valid;
	always_comb
	begin
		logic [2:0] j;
		j = 3'h0;
		isr_level = 3'h0;
		isr_valid = 1'b0;
		for (int k = 7; k >= 0; k--)
		begin
			j = lowest + 3'(k + 1);
			if (in_service[j])
			begin
				isr_level = j;
				isr_valid = 1'b1;
			end
		end
	end

	// End-of-interrupt word decode
	wire eoi_ns = is_eoi_word && (code == `CODE_NS_EOI
		|| code == `CODE_ROT_NS_EOI);
	wire eoi_sp = is_eoi_word && (code == `CODE_SP_EOI
		|| code == `CODE_ROT_SP_EOI);
	wire rot_ns = is_eoi_word && code == `CODE_ROT_NS_EOI;
	wire rot_sp = is_eoi_word && (code == `CODE_ROT_SP_EOI
		|| code == `CODE_SET_PRIO);
	wire auto_clear = ack_end && ack_taken && cfg.auto_eoi_sel;
	wire [7:0] ns_clear = (eoi_ns && isr_valid) ? (8'h01 << isr_level)
		: 8'h00;
	wire [7:0] sp_clear = eoi_sp ? (8'h01 << level) : 8'h00;
	wire [7:0] auto_mask = auto_clear ? (8'h01 << taken_level) : 8'h00;
	wire ack_start_w = ack_sync && !ack_prev;
	wire ack_set = ack_start_w && top_valid && ready;
	wire [7:0] set_isr = ack_set ? (8'h01 << top_level) : 8'h00;
	wire [7:0] rise = req_sync & ~req_prev;

	// Request, in-service, mask and priority state; sets win over clears, but word one clears over all except a same-cycle automatic rotation of lowest
	always_ff @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			mask <= `MASK_RESET;
			pending <= 8'h00;
			in_service <= 8'h00;
			req_prev <= 8'h00;
			lowest <= 3'h7;
			rotate_auto <= 1'b0;
			read_isr <= 1'b0;
			ack_taken <= 1'b0;
			taken_level <= 3'h0;
		end
		else if (enable_i)
		begin
			req_prev <= req_sync;
			// Masked lines keep pending bits; mask only gates selection
			pending <= (pending & ~set_isr) | (ready ? rise : 8'h00);
			in_service <= (in_service & ~(ns_clear | sp_clear | auto_mask))
				| set_isr;
			if (is_word_one)
			begin
				mask <= `MASK_RESET;
				in_service <= 8'h00;
				pending <= 8'h00;
				lowest <= 3'h7;
				rotate_auto <= 1'b0;
				read_isr <= 1'b0;
			end
			if (is_mask_word && ready)
				mask <= d;
			if (is_eoi_word && code == `CODE_ROT_AUTO_SET)
				rotate_auto <= 1'b1;
			if (is_eoi_word && code == `CODE_ROT_AUTO_CLR)
				rotate_auto <= 1'b0;
			if (rot_ns && isr_valid)
				lowest <= isr_level;
			else if (rot_sp)
				lowest <= level;
			else if (auto_clear && rotate_auto)
				lowest <= taken_level;
			if (is_readsel && d[`BIT_READ_REG])
				read_isr <= d[`BIT_READ_ISR];
			if (ack_set)
			begin
				ack_taken <= 1'b1;
				taken_level <= top_level;
			end
			else if (ack_end)
				ack_taken <= 1'b0;
		end
	end

	// Registered outputs; shared pin mode follows the buffered bit
	always_ff @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			role_or_buffer_enable_pin_o <= 1'b1;
			role_or_buffer_enable_pin_oe_o <= 1'b0;
			read_data_o <= 8'h00;
			irq_o <= 1'b0;
			ack_level_o <= 3'h0;
			is_master_o <= 1'b1;
			special_nested_o <= 1'b0;
			processor_mode_o <= 1'b0;
			ready_o <= 1'b0;
		end
		else if (enable_i)
		begin
			// Enable is active low while the host reads from us
			role_or_buffer_enable_pin_oe_o <= cfg.buffered;
			role_or_buffer_enable_pin_o <= !(cfg.buffered && rd_sync);
			is_master_o <= cfg.buffered ? cfg.master : pin_sync;
			special_nested_o <= cfg.special_nested_sel;
			processor_mode_o <= cfg.processor_mode_sel;
			if (rd_start)
				read_data_o <= read_isr ? in_service : pending;
			irq_o <= ready && top_valid;
			if (ack_set)
				ack_level_o <= top_level;
			ready_o <= ready;
		end
	end
endmodule : prio_irq_command_words

// [sim/prio_irq_props.sv]
// Port checker for the command-word block
`timescale 1ns/1ps
module prio_irq_props #(
	parameter int LINES = 8
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire prio_irq_pkg::host_access_t host_i,
	input wire logic [LINES-1:0] request_line_i,
	input wire logic ack_i,
	input wire logic role_or_buffer_enable_pin_i,
	input wire logic role_or_buffer_enable_pin_o,
	input wire logic role_or_buffer_enable_pin_oe_o,
	input wire logic [7:0] read_data_o,
	input wire logic irq_o,
	input wire logic [2:0] ack_level_o,
	input wire logic is_master_o,
	input wire logic special_nested_o,
	input wire logic processor_mode_o,
	input wire logic ready_o
);
	import prio_irq_pkg::*;
	wire logic oe = role_or_buffer_enable_pin_oe_o;
	wire logic pin = role_or_buffer_enable_pin_i;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	// Quiet spans outlast the two-stage strobe synchronisers
	sequence quiet_wr;
		!host_i.wr [*6];
	endsequence
	sequence quiet_rd;
		!host_i.rd [*6];
	endsequence
	sequence quiet_ack;
		!ack_i [*5];
	endsequence
	buf_idle_a: assert property (
		(oe && !host_i.rd) [*5] |-> role_or_buffer_enable_pin_o)
		else $error("buffer enable low while idle");
	buf_read_a: assert property (
		(oe && host_i.rd) [*5] |-> !role_or_buffer_enable_pin_o)
		else $error("buffer enable high during read");
	role_pin_a: assert property (
		(!oe && $stable(pin)) [*5] |-> is_master_o == pin)
		else $error("role does not follow pin");
	irq_ready_a: assert property (
		!ready_o [*2] |-> !irq_o)
		else $error("request raised before ready");
	mode_hold_a: assert property (
		(ready_o && !host_i.wr) [*6] |=>
		$stable({special_nested_o, processor_mode_o, oe}))
		else $error("mode changed without a write");
	restart_cause_a: assert property (
		quiet_wr |=> !$fell(ready_o))
		else $error("ready dropped without a write");
	read_hold_a: assert property (
		quiet_rd |=> $stable(read_data_o))
		else $error("read data changed without a read");
	level_hold_a: assert property (
		quiet_ack |=> $stable(ack_level_o))
		else $error("level changed without acknowledge");
	irq_keep_a: assert property (
		(!ack_i && !host_i.wr) [*8] |=> !$fell(irq_o))
		else $error("request dropped without acknowledge or write");
endmodule : prio_irq_props
bind prio_irq_command_words prio_irq_props #(.LINES(LINES)) props_i (.*);

// [sim/prio_irq_host.sv]
// Host processor model: command writes, reads, acknowledges
`timescale 1ns/1ps
module prio_irq_host (
	input wire logic clock_i,
	input wire logic pin_i,
	input wire logic [7:0] rd_data_i,
	output prio_irq_pkg::host_access_t host_o,
	output logic ack_o
);
	import prio_irq_pkg::*;
	initial
	begin
		host_o = '0;
		ack_o = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step
	// Word held 4 cycles past the strobe, then the bus shows garbage
	task automatic put(input logic sel, input logic [7:0] w);
		host_o.register_select_line = sel;
		host_o.data = w;
		host_o.wr = 1'b1;
		step(4);
		host_o.wr = 1'b0;
		step(4);
		host_o.data = ~w;
		step(3);
	endtask : put
	task automatic get(output logic [7:0] d, output logic en);
		host_o.rd = 1'b1;
		step(5);
		d = rd_data_i;
		en = pin_i;
		host_o.rd = 1'b0;
		step(5);
	endtask : get
	task automatic pulse;
		ack_o = 1'b1;
		step(4);
		ack_o = 1'b0;
		step(5);
	endtask : pulse
endmodule : prio_irq_host

// [sim/prio_irq_command_words_tb.sv]
// Self-checking bench for the command-word block
`timescale 1ns/1ps
module prio_irq_command_words_tb;
	import prio_irq_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic enable_i = 1'b1;
	logic [7:0] request_line_i = 8'h00;
	logic drv = 1'b1;
	host_access_t host_i;
	logic ack_i, pin_o, oe, irq_o, is_master_o, ready_o, e;
	logic special_nested_o, processor_mode_o;
	logic [7:0] read_data_o, d;
	logic [2:0] ack_level_o;
	int fails = 0;
	int n_compared = 0;
	// Shared pin: the block wins while its driver is enabled
	wire logic pin_w = oe ? pin_o : drv;
	wire logic [7:0] st = {3'h0, ready_o, processor_mode_o,
		special_nested_o, oe, is_master_o};
	always #10 clock_i = ~clock_i;
	prio_irq_command_words #(.LINES(8)) DUT (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.enable_i(enable_i),
		.host_i(host_i),
		.request_line_i(request_line_i),
		.ack_i(ack_i),
		.role_or_buffer_enable_pin_i(pin_w),
		.role_or_buffer_enable_pin_o(pin_o),
		.role_or_buffer_enable_pin_oe_o(oe),
		.read_data_o(read_data_o),
		.irq_o(irq_o),
		.ack_level_o(ack_level_o),
		.is_master_o(is_master_o),
		.special_nested_o(special_nested_o),
		.processor_mode_o(processor_mode_o),
		.ready_o(ready_o)
	);
	prio_irq_host host (.clock_i(clock_i), .pin_i(pin_w),
		.rd_data_i(read_data_o), .host_o(host_i), .ack_o(ack_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic in_service_register, input logic [7:0] exp);
		host.put(1'b0, {7'h05, in_service_register});
		host.get(d, e);
		chk(d, exp);
	endtask : rdchk
	// Settle time covers edge detect plus request output register
	task automatic rq(input logic [7:0] v);
		request_line_i = v;
		host.step(5);
	endtask : rq
	task automatic ackchk(input logic [2:0] exp);
		host.pulse();
		chk({5'h00, ack_level_o}, {5'h00, exp});
	endtask : ackchk
	// Cascaded sequence, so word three comes before word four
	task automatic init(input logic [7:0] w4);
		host.put(1'b0, 8'h11);
		host.put(1'b1, 8'h20);
		chk({7'h00, ready_o}, 8'h00);
		host.put(1'b1, 8'h04);
		host.put(1'b1, w4);
	endtask : init
	task automatic wrap_up;
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end
	initial
	begin
		repeat (20) @(posedge clock_i);
		#1 rst_n_i = 1'b1;
		host.step(5);
		chk(st, 8'h01);
		host.put(1'b0, 8'h12);
		host.put(1'b1, 8'h20);
		chk(st, 8'h11);
		rq(8'h08);
		chk({7'h00, irq_o}, 8'h01);
		rdchk(1'b0, 8'h08);
		host.put(1'b1, 8'h08);
		chk({7'h00, irq_o}, 8'h00);
		rdchk(1'b0, 8'h08);
		host.put(1'b1, 8'h00);
		chk({7'h00, irq_o}, 8'h01);
		ackchk(3'h3);
		rdchk(1'b1, 8'h08);
		host.put(1'b0, 8'h20);
		rdchk(1'b1, 8'h00);
		rq(8'h2C);
		ackchk(3'h2);
		ackchk(3'h5);
		host.put(1'b0, 8'h65);
		host.put(1'b0, 8'h42);
		rdchk(1'b1, 8'h04);
		host.put(1'b0, 8'h08);
		host.get(d, e);
		chk(d, 8'h04);
		host.put(1'b0, 8'h20);
		rq(8'h00);
		rq(8'h02);
		ackchk(3'h1);
		host.put(1'b0, 8'hE1);
		rq(8'h07);
		ackchk(3'h2);
		host.put(1'b0, 8'hC7);
		ackchk(3'h0);
		host.put(1'b0, 8'h20);
		host.put(1'b0, 8'h20);
		rdchk(1'b1, 8'h00);
		rq(8'h40);
		ackchk(3'h6);
		host.put(1'b0, 8'hA0);
		rq(8'hE0);
		ackchk(3'h7);
		rq(8'h00);
		host.put(1'b0, 8'h13);
		chk({7'h00, ready_o}, 8'h00);
		host.put(1'b1, 8'h20);
		host.put(1'b1, 8'h03);
		chk(st, 8'h19);
		rq(8'h10);
		ackchk(3'h4);
		rdchk(1'b1, 8'h00);
		host.put(1'b0, 8'h80);
		rq(8'h00);
		rq(8'h10);
		ackchk(3'h4);
		rq(8'h38);
		ackchk(3'h5);
		host.put(1'b0, 8'h00);
		init(8'h1C);
		chk(st, 8'h17);
		host.get(d, e);
		chk({7'h00, e}, 8'h00);
		init(8'h08);
		chk(st, 8'h12);
		drv = 1'b0;
		init(8'h00);
		chk(st, 8'h10);
		drv = 1'b1;
		host.step(5);
		chk(st, 8'h11);
		// Clock enable low: a new request edge must not get through
		enable_i = 1'b0;
		rq(8'h39);
		chk({7'h00, irq_o}, 8'h00);
		enable_i = 1'b1;
		rq(8'h39);
		chk({7'h00, irq_o}, 8'h01);
		ackchk(3'h0);
		wrap_up();
	end
endmodule : prio_irq_command_words_tb
